// ### hdl/buck_boost_mode_sequencer.sv
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module buck_boost_mode_sequencer #(
  parameter int unsigned HICCUP_CYCLES = mode_seq_pkg::HICCUP_CYC,
  parameter int unsigned BYPASS_CYCLES = mode_seq_pkg::BYPASS_GAP_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       uvlo_ok,
  input  wire logic       temp_hot,
  input  wire logic       temp_cool,
  input  wire logic       peak_limit,
  input  wire logic       pfm_upper,
  input  wire logic       pfm_lower,
  input  wire logic       load_light,
  input  wire logic       vin_above_vout,
  input  wire logic       vin_near_vout,
  input  wire logic       pwm_phase,
  input  wire logic       otp_done,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  output logic            sw_a,
  output logic            sw_b,
  output logic            sw_c,
  output logic            sw_d,
  output logic            sw_bypass,
  output logic            discharge_on,
  output logic            blocks_on,
  output logic            otp_load,
  output logic [7:0]      vout_target
);
  import mode_seq_pkg::*;

  seq_state_t  state;
  logic [7:0]  vset;
  logic [7:0]  converter_config_reg;
  logic [7:0]  fault_cfg;
  logic [3:0]  fault_flag_reg;
  logic [23:0] wait_cnt;
  logic [15:0] ramp_cnt;
  logic [7:0]  ramp_code;
  logic        pfm_run;
  logic        boost_energise;
  logic [2:0]  hot_sync;
  logic [2:0]  cool_sync;
  logic [2:0]  lim_sync;
  logic [2:0]  uv_sync;
  logic        hot_q;
  logic        cool_q;
  logic        lim_q;
  logic        uv_q;
  logic        conv_en;
  logic        want_bypass;
  logic        oc_event;
  logic        ot_event;
  logic [1:0]  forced_mode_select;
  logic [1:0]  ramp_rate_select;
  logic [1:0]  overcurrent_response_select;
  logic        discharge_select;
  logic [7:0]  vset_eff;
  logic        next_a;
  logic        next_b;
  logic        next_c;
  logic        next_d;
  logic        near_boost;
  logic        phase_q;
  logic        buck_sel;
  logic        pfm_sel;
  logic        pfm_trip;
  logic        limit_hold;

  function automatic logic [15:0] ramp_period(input logic [1:0] code);
    case (code)
      2'h0:    ramp_period = 16'(RAMP_CYC_R0);
      2'h1:    ramp_period = 16'(RAMP_CYC_R1);
      2'h2:    ramp_period = 16'(RAMP_CYC_R2);
      default: ramp_period = 16'(RAMP_CYC_R3);
    endcase
  endfunction

  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[2] == s[1]) ? s[1] : prev;
  endfunction

  assign forced_mode_select          = converter_config_reg[CFG_FORCED_MODE_SELECT_HI:CFG_FORCED_MODE_SELECT_LO];
  assign ramp_rate_select            = converter_config_reg[CFG_RATE_HI:CFG_RATE_LO];
  assign discharge_select            = converter_config_reg[CFG_DISCHARGE_SELECT_BIT];
  assign overcurrent_response_select = fault_cfg[1:0];
  assign conv_en   = uv_q && converter_config_reg[CFG_GATE_BIT];
  assign want_bypass = (forced_mode_select == FORCED_MODE_SELECT_BYPASS);
  assign vset_eff  = (vset > VSET_MAX) ? VSET_MAX : ((vset < VSET_MIN) ? VSET_MIN : vset);
  assign buck_sel  = vin_above_vout || (vin_near_vout && !near_boost);
  assign pfm_sel   = (forced_mode_select != FORCED_MODE_SELECT_PWM) && load_light;
  // In boost PFM the peak comparator is the energise threshold, so it must not read as an overcurrent.
  assign pfm_trip  = pfm_sel && !buck_sel && (state == ST_RAMP || state == ST_REG);
  assign oc_event  = lim_q && !pfm_trip && (state != ST_BYPASS) && (state != ST_OFF);
  assign limit_hold = lim_q && !pfm_trip && (overcurrent_response_select == OCR_LIMIT);
  assign ot_event  = hot_q;

  // Temperature, current-limit and UVLO comparator outputs are asynchronous to the control clock, so each is filtered.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hot_sync  <= 3'h0;
      cool_sync <= 3'h0;
      lim_sync  <= 3'h0;
      uv_sync   <= 3'h0;
      hot_q     <= 1'b0;
      cool_q    <= 1'b0;
      lim_q     <= 1'b0;
      uv_q      <= 1'b0;
    end else begin
      hot_sync  <= {hot_sync[1:0], temp_hot};
      cool_sync <= {cool_sync[1:0], temp_cool};
      lim_sync  <= {lim_sync[1:0], peak_limit};
      uv_sync   <= {uv_sync[1:0], uvlo_ok};
      hot_q     <= filt(hot_sync, hot_q);
      cool_q    <= filt(cool_sync, cool_q);
      lim_q     <= filt(lim_sync, lim_q);
      uv_q      <= filt(uv_sync, uv_q);
    end
  end

  // Register writes; the enable pin acts as rst_b, so a low pin returns every register to its reset value.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      vset                 <= VSET_RESET;
      converter_config_reg <= CONVERTER_CONFIG_REG_RESET;
      fault_cfg            <= FAULT_CFG_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_VSET:      vset                 <= reg_wdata;
        ADDR_CONVERTER_CONFIG_REG:  converter_config_reg <= reg_wdata;
        ADDR_FAULT_CFG: fault_cfg            <= reg_wdata;
        default:        ;
      endcase
    end
  end

  // Read data lands one cycle after the strobe; the flag read clears, but a new event wins.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata      <= 8'h00;
      fault_flag_reg <= 4'h0;
    end else begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_FAULT_FLAG: reg_rdata <= {4'h0, fault_flag_reg};
          ADDR_VSET:       reg_rdata <= vset;
          ADDR_CONVERTER_CONFIG_REG:   reg_rdata <= converter_config_reg;
          ADDR_FAULT_CFG:  reg_rdata <= fault_cfg;
          ADDR_STATUS:     reg_rdata <= {5'h00, state};
          default:         reg_rdata <= 8'h00;
        endcase
      end
      fault_flag_reg <= ((reg_rd && reg_addr == ADDR_FAULT_FLAG) ? 4'h0 : fault_flag_reg)
                        | {vset < VSET_MIN, vset > VSET_MAX, ot_event, oc_event};
    end
  end

  // Main sequence.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= ST_OFF;
      wait_cnt  <= 24'h000000;
      ramp_cnt  <= 16'h0000;
      ramp_code <= 8'h00;
    end else begin
      case (state)
        ST_OFF: begin
          ramp_code <= 8'h00;
          if (conv_en) begin
            state    <= ST_INIT;
            wait_cnt <= 24'h000000;
          end
        end
        ST_INIT: begin
          if (!conv_en) begin
            state <= ST_OFF;
          end else if (otp_done) begin
            state    <= want_bypass ? ST_BYPASS : ST_RAMP;
            wait_cnt <= 24'h000000;
            ramp_cnt <= 16'h0000;
          end
        end
        ST_RAMP: begin
          if (ramp_cnt + 16'h0001 >= ramp_period(ramp_rate_select)) begin
            ramp_cnt <= 16'h0000;
            if (ramp_code < vset_eff) begin
              ramp_code <= (ramp_code < VSET_MIN) ? VSET_MIN : ramp_code + 8'h01;
            end else begin
              ramp_code <= vset_eff;
              state     <= ST_REG;
            end
          end else begin
            ramp_cnt <= ramp_cnt + 16'h0001;
          end
          if (wait_cnt < 24'(BYPASS_CYCLES)) begin
            wait_cnt <= wait_cnt + 24'h000001;
          end
        end
        ST_REG: begin
          // A higher setting ramps again; a lower one is taken at once.
          if (vset_eff > ramp_code) begin
            state <= ST_RAMP;
          end else begin
            ramp_code <= vset_eff;
          end
          if (wait_cnt < 24'(BYPASS_CYCLES)) begin
            wait_cnt <= wait_cnt + 24'h000001;
          end
          if (want_bypass && wait_cnt >= 24'(BYPASS_CYCLES)) begin
            state    <= ST_BYPASS;
            wait_cnt <= 24'h000000;
          end
        end
        ST_BYPASS: begin
          if (wait_cnt < 24'(BYPASS_CYCLES)) begin
            wait_cnt <= wait_cnt + 24'h000001;
          end
          if (!want_bypass && wait_cnt >= 24'(BYPASS_CYCLES)) begin
            state    <= ST_RAMP;
            wait_cnt <= 24'h000000;
            ramp_cnt <= 16'h0000;
          end
        end
        ST_HICCUP: begin
          if (wait_cnt + 24'h000001 >= 24'(HICCUP_CYCLES)) begin
            state    <= ST_INIT;
            wait_cnt <= 24'h000000;
          end else begin
            wait_cnt <= wait_cnt + 24'h000001;
          end
        end
        ST_THERMAL: begin
          ramp_code <= 8'h00;
          if (cool_q && !hot_q) begin
            state    <= ST_RAMP;
            ramp_cnt <= 16'h0000;
            wait_cnt <= 24'h000000;
          end
        end
        ST_LATCH: ramp_code <= 8'h00;
        default:  state <= ST_OFF;
      endcase
      if (state != ST_OFF && state != ST_INIT && !conv_en) begin
        state <= ST_OFF;
      end else if (hot_q && state != ST_OFF && state != ST_THERMAL) begin
        state <= ST_THERMAL;
      end else if (oc_event && state != ST_HICCUP && state != ST_LATCH) begin
        if (overcurrent_response_select == OCR_HICCUP) begin
          state     <= ST_HICCUP;
          wait_cnt  <= 24'h000000;
          ramp_code <= 8'h00;
        end else if (overcurrent_response_select == OCR_SHUTDOWN) begin
          state <= ST_LATCH;
        end
      end
    end
  end

  // Hysteretic PFM burst and boost energise phase.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pfm_run        <= 1'b0;
      boost_energise <= 1'b0;
      phase_q        <= 1'b0;
      near_boost     <= 1'b0;
    end else begin
      phase_q <= pwm_phase;
      // Near balance the stage hands over between buck and boost once per switching period.
      if (phase_q && !pwm_phase) begin
        near_boost <= !near_boost;
      end
      if (pfm_upper) begin
        pfm_run <= 1'b0;
      end else if (pfm_lower) begin
        pfm_run <= 1'b1;
      end
      if (lim_q) begin
        boost_energise <= 1'b0;
      end else if (!pwm_phase) begin
        boost_energise <= 1'b1;
      end
    end
  end

  // Switch pattern selection.
  always_comb begin
    next_a = 1'b0;
    next_b = 1'b0;
    next_c = 1'b0;
    next_d = 1'b0;
    if ((state == ST_RAMP || state == ST_REG) && !limit_hold) begin
      if (buck_sel) begin
        next_d = 1'b1;
        if (forced_mode_select == FORCED_MODE_SELECT_PWM || !load_light) begin
          next_a = pwm_phase;
          next_b = !pwm_phase;
        end else if (pfm_run) begin
          next_a = pwm_phase;
          next_b = !pwm_phase && !pfm_upper;
        end
      end else begin
        if (forced_mode_select == FORCED_MODE_SELECT_PWM || !load_light) begin
          next_a = 1'b1;
          next_c = pwm_phase;
          next_d = !pwm_phase;
        end else if (pfm_run) begin
          next_a = 1'b1;
          next_c = boost_energise;
          next_b = !boost_energise;
          next_d = !boost_energise;
          next_a = boost_energise;
        end
      end
    end else if (state == ST_BYPASS) begin
      next_a = 1'b1;
      next_d = 1'b1;
    end
    next_b = next_b && !next_a;
    next_c = next_c && !next_d;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_a         <= 1'b0;
      sw_b         <= 1'b0;
      sw_c         <= 1'b0;
      sw_d         <= 1'b0;
      sw_bypass    <= 1'b0;
      discharge_on <= 1'b0;
      blocks_on    <= 1'b0;
      otp_load     <= 1'b0;
      vout_target  <= 8'h00;
    end else begin
      sw_a         <= next_a;
      sw_b         <= next_b;
      sw_c         <= next_c;
      sw_d         <= next_d;
      sw_bypass    <= (state == ST_BYPASS);
      // The resistor waits until the switches have stopped, so it never loads a running stage.
      discharge_on <= discharge_select && !converter_config_reg[CFG_GATE_BIT] && (state == ST_OFF);
      blocks_on    <= (state != ST_OFF) && (state != ST_BYPASS);
      otp_load     <= (state == ST_INIT);
      vout_target  <= ramp_code;
    end
  end

endmodule

// ### hdl/mode_seq_pkg.sv
package mode_seq_pkg;

  localparam int unsigned CLK_HZ = 10000000;

  // Register indices on the plain register port.
  localparam logic [7:0] ADDR_FAULT_FLAG  = 8'h03;
  localparam logic [7:0] ADDR_VSET        = 8'h11;
  localparam logic [7:0] ADDR_CONVERTER_CONFIG_REG    = 8'h12;
  localparam logic [7:0] ADDR_FAULT_CFG   = 8'h13;
  localparam logic [7:0] ADDR_STATUS      = 8'h14;

  // Converter configuration field layout.
  localparam int CFG_GATE_BIT   = 7;
  localparam int CFG_DISCHARGE_SELECT_BIT  = 6;
  localparam int CFG_RATE_HI    = 5;
  localparam int CFG_RATE_LO    = 4;
  localparam int CFG_FORCED_MODE_SELECT_HI   = 1;
  localparam int CFG_FORCED_MODE_SELECT_LO   = 0;
  localparam logic [7:0] CONVERTER_CONFIG_REG_RESET  = 8'h80;
  localparam logic [7:0] VSET_RESET      = 8'h84;
  localparam logic [7:0] FAULT_CFG_RESET = 8'h00;

  // Fault flag bit positions.
  localparam int FLAG_OC_BIT    = 0;
  localparam int FLAG_OT_BIT    = 1;
  localparam int FLAG_OVR_BIT   = 2;
  localparam int FLAG_UNDR_BIT  = 3;

  // Output setting limits in 25 mV codes.
  localparam logic [7:0] VSET_MIN = 8'h48;
  localparam logic [7:0] VSET_MAX = 8'hD7;

  // Ramp step period per code, in nanoseconds per 25 mV code step.
  localparam int unsigned RAMP_NS_R0 = 8000;
  localparam int unsigned RAMP_NS_R1 = 4000;
  localparam int unsigned RAMP_NS_R2 = 32000;
  localparam int unsigned RAMP_NS_R3 = 16000;
  localparam int unsigned RAMP_CYC_R0 = RAMP_NS_R0 / 100;
  localparam int unsigned RAMP_CYC_R1 = RAMP_NS_R1 / 100;
  localparam int unsigned RAMP_CYC_R2 = RAMP_NS_R2 / 100;
  localparam int unsigned RAMP_CYC_R3 = RAMP_NS_R3 / 100;

  localparam int unsigned HICCUP_MS      = 100;
  localparam int unsigned HICCUP_CYC     = HICCUP_MS * (CLK_HZ / 1000);
  localparam int unsigned BYPASS_GAP_MS  = 1;
  localparam int unsigned BYPASS_GAP_CYC = BYPASS_GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned OTP_US         = 125;
  localparam int unsigned OTP_CYC        = OTP_US * (CLK_HZ / 1000000);

  localparam logic [1:0] FORCED_MODE_SELECT_AUTO   = 2'h0;
  localparam logic [1:0] FORCED_MODE_SELECT_PWM    = 2'h1;
  localparam logic [1:0] FORCED_MODE_SELECT_BYPASS = 2'h2;

  localparam logic [1:0] OCR_HICCUP   = 2'h0;
  localparam logic [1:0] OCR_SHUTDOWN = 2'h1;
  localparam logic [1:0] OCR_LIMIT    = 2'h2;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_INIT    = 3'b001,
    ST_RAMP    = 3'b010,
    ST_REG     = 3'b011,
    ST_HICCUP  = 3'b100,
    ST_LATCH   = 3'b101,
    ST_THERMAL = 3'b110,
    ST_BYPASS  = 3'b111
  } seq_state_t;

endpackage

// ### verif/mode_seq_props.sv
`timescale 1ns/1ps
module mode_seq_props (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       temp_hot,
  input wire logic       sw_a,
  input wire logic       sw_b,
  input wire logic       sw_c,
  input wire logic       sw_d,
  input wire logic       sw_bypass,
  input wire logic       discharge_on,
  input wire logic       blocks_on,
  input wire logic       otp_load,
  input wire logic [7:0] vout_target
);
  logic seen_init;
  logic any_sw;
  assign any_sw = sw_a | sw_b | sw_c | sw_d;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Remembers that the stored settings were loaded since the last enable.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_init <= 1'b0;
    end else if (otp_load) begin
      seen_init <= 1'b1;
    end
  end
  chk_ab_apart: assert property (!(sw_a && sw_b))
    else $error("switches a and b closed together");
  chk_cd_apart: assert property (!(sw_c && sw_d))
    else $error("switches c and d closed together");
  chk_bypass_path: assert property (sw_bypass |-> sw_a && sw_d && !sw_b && !sw_c && !blocks_on)
    else $error("bypass path not as expected");
  chk_discharge_quiet: assert property (discharge_on |-> !any_sw && !sw_bypass)
    else $error("switching while discharge resistor connected");
  chk_hot_halts: assert property (temp_hot [*7] |-> !any_sw || sw_bypass)
    else $error("switching while hot");
  chk_init_first: assert property (any_sw |-> seen_init)
    else $error("switching before settings loaded");
  chk_init_idle: assert property (otp_load |-> !any_sw)
    else $error("switching during init");
  chk_ramp_step: assert property ((vout_target > $past(vout_target)) && ($past(vout_target) != 8'h00)
    |-> vout_target == $past(vout_target) + 8'h01)
    else $error("target rose by more than one code");
  chk_buck_side: assert property (sw_b |-> sw_d && !sw_c)
    else $error("low switch b closed without d");
  chk_boost_side: assert property (sw_c |-> sw_a && !sw_b)
    else $error("low switch c closed without a");
endmodule
bind buck_boost_mode_sequencer mode_seq_props chk_u (.core_clk(core_clk), .rst_b(rst_b), .temp_hot(temp_hot),
  .sw_a(sw_a), .sw_b(sw_b), .sw_c(sw_c), .sw_d(sw_d), .sw_bypass(sw_bypass), .discharge_on(discharge_on),
  .blocks_on(blocks_on), .otp_load(otp_load), .vout_target(vout_target));

// ### verif/converter_far_side.sv
`timescale 1ns/1ps
module converter_far_side (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic sw_a,
  input  wire logic sw_c,
  input  wire logic otp_load,
  input  wire logic hot_req,
  input  wire logic short_req,
  output logic      temp_hot,
  output logic      temp_cool,
  output logic      peak_limit,
  output logic      pwm_phase,
  output logic      otp_done
);
  logic [1:0] phase_cnt;
  logic [3:0] charge_cnt;
  logic [2:0] load_cnt;
  assign temp_hot   = hot_req;
  assign temp_cool  = !hot_req;
  assign pwm_phase  = phase_cnt[1];
  // Inductor current builds while a and c conduct and trips the threshold after three cycles.
  assign peak_limit = short_req || (charge_cnt >= 4'h3);
  assign otp_done   = (load_cnt == 3'h7);
  always_ff @(posedge core_clk) begin
    phase_cnt <= phase_cnt + 2'h1;
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      charge_cnt <= 4'h0;
      load_cnt   <= 3'h0;
    end else begin
      charge_cnt <= (sw_a && sw_c) ? charge_cnt + {3'h0, charge_cnt != 4'hF} : 4'h0;
      load_cnt   <= otp_load ? load_cnt + {2'h0, load_cnt != 3'h7} : 3'h0;
    end
  end
  initial phase_cnt = 2'h0;
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import mode_seq_pkg::*;
  logic       core_clk, rst_b, uvlo_ok, pfm_upper, pfm_lower, load_light, vin_above_vout, vin_near_vout;
  logic       hot_req, short_req, reg_wr, reg_rd, temp_hot, temp_cool, peak_limit, pwm_phase, otp_done;
  logic       sw_a, sw_b, sw_c, sw_d, sw_bypass, discharge_on, blocks_on, otp_load;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, vout_target, rd_v, win_v;
  int         fail_count, cmp_count, n;
  buck_boost_mode_sequencer #(.HICCUP_CYCLES(200), .BYPASS_CYCLES(50)) dut_u (.core_clk(core_clk), .rst_b(rst_b),
    .uvlo_ok(uvlo_ok), .temp_hot(temp_hot), .temp_cool(temp_cool), .peak_limit(peak_limit), .pfm_upper(pfm_upper),
    .pfm_lower(pfm_lower), .load_light(load_light), .vin_above_vout(vin_above_vout), .vin_near_vout(vin_near_vout),
    .pwm_phase(pwm_phase), .otp_done(otp_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sw_a(sw_a), .sw_b(sw_b), .sw_c(sw_c), .sw_d(sw_d),
    .sw_bypass(sw_bypass), .discharge_on(discharge_on), .blocks_on(blocks_on), .otp_load(otp_load),
    .vout_target(vout_target));
  converter_far_side far_u (.core_clk(core_clk), .rst_b(rst_b), .sw_a(sw_a), .sw_c(sw_c), .otp_load(otp_load),
    .hot_req(hot_req), .short_req(short_req), .temp_hot(temp_hot), .temp_cool(temp_cool),
    .peak_limit(peak_limit), .pwm_phase(pwm_phase), .otp_done(otp_done));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk) reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  // Polls the status register; n ends as the number of extra reads, two cycles each.
  task automatic wst(input logic [2:0] s, input int lim);
    n = 0;
    rd(ADDR_STATUS);
    while (rd_v[2:0] !== s && n < lim) begin
      rd(ADDR_STATUS);
      n++;
    end
    chk({5'h0, rd_v[2:0]}, {5'h0, s}, "state");
  endtask
  task automatic win;
    logic [3:0] o, an;
    o = 4'h0;
    an = 4'hF;
    repeat (8) @(posedge core_clk);
    repeat (16) begin
      @(posedge core_clk) #1;
      o = o | {sw_a, sw_b, sw_c, sw_d};
      an = an & {sw_a, sw_b, sw_c, sw_d};
    end
    win_v = {o, an};
  endtask
  task automatic sw_off(input string m);
    chk({3'h0, sw_a, sw_b, sw_c, sw_d, sw_bypass}, 8'h00, m);
  endtask
  task automatic t_startup;
    rd(ADDR_VSET); chk(rd_v, VSET_RESET, "vset reset");
    rd(ADDR_CONVERTER_CONFIG_REG); chk(rd_v, CONVERTER_CONFIG_REG_RESET, "config reset");
    rd(ADDR_FAULT_CFG); chk(rd_v, FAULT_CFG_RESET, "fault config reset");
    rd(8'hFF); chk(rd_v, 8'h00, "unmapped read");
    wst(3'h0, 10);
    uvlo_ok <= 1'b1;
    wst(3'h1, 20); sw_off("init");
    wst(3'h2, 20);
    n = 0;
    while (vout_target !== VSET_RESET && n < 6000) @(posedge core_clk) n++;
    chk({7'h0, n >= 4700 && n <= 4900}, 8'h01, "soft-start time");
    wst(3'h3, 50);
    $display("startup test done");
  endtask
  task automatic t_modes;
    win; chk(win_v, 8'hD1, "buck pwm");
    vin_above_vout <= 1'b0;
    win; chk(win_v, 8'hB8, "boost pwm");
    vin_near_vout <= 1'b1;
    win; chk(win_v & 8'h60, 8'h60, "buck and boost alternate");
    {vin_near_vout, vin_above_vout, load_light, pfm_lower} <= 4'b0111;
    win; chk(win_v & 8'hA0, 8'h80, "buck pfm");
    {pfm_upper, pfm_lower} <= 2'b10;
    win; chk(win_v & 8'hE0, 8'h00, "pfm idle above upper");
    {vin_above_vout, pfm_upper, pfm_lower} <= 3'b001;
    win; chk(win_v & 8'hE0, 8'hE0, "boost pfm phases");
    // Stop the burst and let the current comparator settle before leaving boost PFM.
    {pfm_upper, pfm_lower} <= 2'b10;
    repeat (8) @(posedge core_clk);
    wr(ADDR_CONVERTER_CONFIG_REG, 8'h81);
    {vin_above_vout, pfm_upper} <= 2'b11;
    win; chk(win_v, 8'hD1, "forced pwm");
    wr(ADDR_CONVERTER_CONFIG_REG, 8'h80);
    {load_light, pfm_upper} <= 2'b00;
    $display("mode test done");
  endtask
  task automatic ramp(input logic [1:0] rc, input int per);
    logic [7:0] t;
    t = vout_target + 8'h04;
    wr(ADDR_CONVERTER_CONFIG_REG, {2'b10, rc, 4'h0});
    wr(ADDR_VSET, t);
    n = 0;
    while (vout_target !== t && n < 20 * per) @(posedge core_clk) n++;
    chk({7'h0, n >= 3 * per && n <= 5 * per}, 8'h01, "ramp slope");
  endtask
  task automatic t_faults;
    wr(ADDR_CONVERTER_CONFIG_REG, 8'h82);
    wst(3'h7, 60);
    chk({2'h0, sw_a, sw_b, sw_c, sw_d, sw_bypass, blocks_on}, 8'h26, "bypass path");
    wr(ADDR_CONVERTER_CONFIG_REG, 8'h80);
    short_req <= 1'b1;
    n = 0;
    while (sw_bypass === 1'b1 && n < 200) begin
      @(posedge core_clk) n++;
      if (n == 30) short_req <= 1'b0;
    end
    chk({7'h0, n >= 40 && n <= 55}, 8'h01, "bypass hold time");
    rd(ADDR_FAULT_FLAG); chk(rd_v & 8'h01, 8'h00, "overcurrent in bypass");
    wst(3'h3, 200);
    short_req <= 1'b1;
    wst(3'h4, 20);
    short_req <= 1'b0;
    sw_off("hiccup off");
    wst(3'h1, 200); chk({7'h0, n >= 95 && n <= 104}, 8'h01, "hiccup time");
    rd(ADDR_FAULT_FLAG); chk(rd_v & 8'h01, 8'h01, "overcurrent flag");
    rd(ADDR_FAULT_FLAG); chk(rd_v, 8'h00, "flag cleared by read");
    wst(3'h3, 3500);
    wr(ADDR_FAULT_CFG, {6'h0, OCR_SHUTDOWN});
    short_req <= 1'b1;
    wst(3'h5, 20);
    short_req <= 1'b0;
    repeat (300) @(posedge core_clk);
    rd(ADDR_STATUS); chk(rd_v, 8'h05, "latched off");
    @(posedge core_clk) rst_b <= 1'b0;
    @(posedge core_clk) #1 chk({sw_a, sw_b, sw_c, sw_d, sw_bypass, discharge_on, blocks_on, otp_load}, 8'h00, "enable low");
    @(posedge core_clk) rst_b <= 1'b1;
    wst(3'h3, 3000);
    wr(ADDR_FAULT_CFG, {6'h0, OCR_LIMIT});
    short_req <= 1'b1;
    repeat (8) @(posedge core_clk) #1;
    sw_off("current limit");
    short_req <= 1'b0;
    rd(ADDR_STATUS); chk(rd_v, 8'h03, "limit keeps state");
    $display("fault test done");
  endtask
  task automatic t_heat_discharge;
    hot_req <= 1'b1;
    wst(3'h6, 20); sw_off("thermal");
    rd(ADDR_FAULT_FLAG); chk(rd_v & 8'h02, 8'h02, "thermal flag");
    hot_req <= 1'b0;
    wst(3'h2, 20); chk({7'h0, vout_target < VSET_RESET}, 8'h01, "thermal restart ramps");
    wst(3'h3, 3000);
    wr(ADDR_CONVERTER_CONFIG_REG, 8'h40);
    repeat (4) @(posedge core_clk) #1;
    chk({3'h0, discharge_on, sw_a, sw_b, sw_c, sw_d}, 8'h10, "discharge on");
    wr(ADDR_CONVERTER_CONFIG_REG, 8'h80);
    wst(3'h1, 20); chk({7'h0, discharge_on}, 8'h00, "gate restart");
    $display("thermal and discharge test done");
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // The run needs about 25000 cycles; more than twice that means a hang.
  initial begin
    #(60000 * 100);
    fail_count++;
    tally_and_finish;
  end
  initial begin
    {rst_b, uvlo_ok, pfm_upper, pfm_lower, load_light, vin_near_vout, hot_req, short_req, reg_wr, reg_rd} = 10'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    vin_above_vout = 1'b1;
    fail_count = 0;
    cmp_count = 0;
    repeat (11) @(posedge core_clk);
    #1 chk({sw_a, sw_b, sw_c, sw_d, sw_bypass, discharge_on, blocks_on, otp_load}, 8'h00, "in reset");
    @(posedge core_clk) rst_b <= 1'b1;
    t_startup;
    t_modes;
    ramp(2'h1, 40);
    ramp(2'h2, 320);
    ramp(2'h3, 160);
    ramp(2'h0, 80);
    $display("ramp rate test done");
    t_faults;
    t_heat_discharge;
    tally_and_finish;
  end
endmodule
